//--- shared/ufb_consts.svh
// Purpose: Offsets, field positions and timing counts of the core
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef UFB_CONSTS_SVH
`define UFB_CONSTS_SVH
// Register offsets
`define UFB_OFS_CTRL 8'h00
`define UFB_OFS_STAT 8'h04
`define UFB_OFS_DATA 8'h08
`define UFB_OFS_BAUD 8'h0C
`define UFB_OFS_ADDR 8'h10
// Reset values and writable bits
`define UFB_BAUD_RST 16'h0010
`define UFB_CTRL_WMASK 32'hFF7F_FFF8
`define UFB_BRK_BIT 23
// Status bit positions
`define UFB_ST_TX_BUFFER_EMPTY_FLAG 0
`define UFB_ST_TDC 1
`define UFB_ST_RXF 2
`define UFB_ST_FERR 3
`define UFB_ST_BRK 4
`define UFB_ST_IDLE 5
`define UFB_ST_MUTE 6
`define UFB_ST_BEV 7
`define UFB_ST_PEND 8
// Word length and stop codes
`define UFB_WL_7 2'h2
`define UFB_WL_9 2'h1
`define UFB_STOP_1 2'h0
`define UFB_STOP_H 2'h1
`define UFB_STOP_2 2'h2
// Oversampling: slots per bit and tick loads
`define UFB_OS_SLOTS 5'h10
`define UFB_TK_BIT 5'h0F
`define UFB_TK_MID 5'h07
`define UFB_TK_STOP2 5'h1F
`define UFB_TK_STOP1H 5'h17
`define UFB_SH_W 4'h9
`endif

//--- shared/ufb_pkg.sv
// Purpose: Types shared by the serial core
// Assumes: Nothing
// Notes: Control word layout is the register layout
`default_nettype none
package ufb_pkg;
   // Control register fields, msb first
   typedef struct packed {
      logic [4:0] output_clock_prescale;
      logic rx_dma_en;
      logic tx_dma_en;
      logic tx_buffer_empty_irq_en;
      logic send_break;
      logic last_bit_clock_pulse;
      logic clock_sample_edge;
      logic clock_idle_level;
      logic clock_output_enable;
      logic rx_pin_invert;
      logic tx_pin_invert;
      logic data_invert;
      logic msb_first_sel;
      logic parity_odd;
      logic parity_enable;
      logic [1:0] stop_length_code;
      logic [1:0] word_length_code;
      logic address_width_sel;
      logic wake_method;
      logic receiver_mute;
      logic receiver_enable;
      logic transmitter_enable;
      logic unit_enable;
      logic [2:0] rsvd;
   } ufb_ctrl_t;
   // Frame state, shared by both shifters
   typedef enum logic [3:0] {
      UFB_S_IDLE = 4'b0001,
      UFB_S_START = 4'b0010,
      UFB_S_DATA = 4'b0100,
      UFB_S_STOP = 4'b1000
   } ufb_fsm_t;
endpackage : ufb_pkg
`default_nettype wire

//--- rtl/ufb_baud.sv
// Purpose: Shared baud generator, 16 oversampling ticks per bit
// Assumes: Divisor at least 16 and stable while enabled
// Notes: Any 16 consecutive ticks span exactly div clocks
`timescale 1ns/100ps
`default_nettype none
`include "ufb_consts.svh"
module ufb_baud #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_s_n,
   // Control
   input wire logic clr,
   input wire logic [DIV_W-1:0] div,
   // Tick
   output logic os_tick
);
   logic [DIV_W:0] acc_r;
   logic [DIV_W:0] acc_nxt;

   assign acc_nxt = acc_r + (DIV_W+1)'(`UFB_OS_SLOTS);

   // Counts toward the divisor, one tick per overflow
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         acc_r <= '0;
         os_tick <= 1'b0;
      end else if (clr) begin
         acc_r <= '0;
         os_tick <= 1'b0;
      end else if (acc_nxt >= {1'b0, div}) begin
         acc_r <= acc_nxt - {1'b0, div};
         os_tick <= 1'b1;
      end else begin
         acc_r <= acc_nxt;
         os_tick <= 1'b0;
      end
   end
endmodule : ufb_baud
`default_nettype wire

//--- rtl/ufb_usart_core.sv
// Purpose: Serial frame core with baud divider and Wishbone registers
// Assumes: Classic Wishbone, 32-bit data, one clock
// Notes: Function
// Function
// - Mute bit enters silence; wake on address or idle per wake bit
// - Address width picks 4-bit or full low-bit node address
// - Word is an address only when its marker bit is set
// - Marker is top data bit: 6/7/8, or 5/6/7 with parity
// - Clock enable drives clock pin; idle level and sample edge set
// - Last-bit pulse option; 5-bit prescaler sets clock rate
// - Frame is start, data bits, stops; parity takes last data slot
// - Idle frame is a data frame length of all ones
// - Break holds all frame bits low then a stop; detected alike
// - Length code 10 gives 7, 00 gives 8, 01 gives 9 bits
// - Stop code 00 one, 01 half, 10 two, 11 one and half
// - Parity replaces top data bit; select 1 odd, 0 even
// - Order bit 1 sends msb first, 0 lsb first, both ways
// - Data invert flips bits; pin inverts swap line levels
// - DMA requests when a word can be written or is ready
// - Baud counter overflow at divisor marks one of 16 slots per bit
// - One generator for both; 16 slots per bit, divisor >= 16
// - Disabling receiver or transmitter resets baud counter
// - Empty flag set while holding register empty; pending bit
// - Empty shifter takes holding word and sends it formatted
// - Enabling transmitter queues one idle frame; a word or break already pending at enable goes out before it
`timescale 1ns/100ps
`default_nettype none
`include "ufb_consts.svh"
module ufb_usart_core #(
   parameter int ADR_W = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial pins
   input wire logic rx_i,
   output logic tx_o,
   output logic ck_o,
   output logic ck_oe,
   // DMA requests
   output logic tx_dma_req,
   output logic rx_dma_req
);
   logic [1:0] rst_q;
   logic rst_s_n;
   ufb_pkg::ufb_ctrl_t c_r;
   ufb_pkg::ufb_ctrl_t c_nxt;
   logic [15:0] baud_r;
   logic [7:0] node_r;
   logic acc, wr, rd, hit_c, hit_s, hit_d, hit_b, hit_a;
   logic [31:0] stat_w, baud_m, node_m;
   logic tx_buffer_empty_flag_r, tdc_r, rxf_r, ferr_r, brk_r, idle_r, mute_r, bev_r;
   logic te_q, re_q, go, go_q, rgo, fell, bclr, os_tick;
   logic idle_pend_r, brk_pend_r, ld_any, ld_data, tx_end;
   ufb_pkg::ufb_fsm_t tx_st, rx_st;
   logic [4:0] tx_tk, rx_tk, stop_tk;
   logic [3:0] tx_bit, rx_bit, n, d;
   logic [8:0] tx_hold, tx_sh, rx_sh, rx_data_r;
   logic k_idle, k_brk, lvl, pb;
   logic [8:0] dmask, amask, tord, rord, raw, rxw, tx_par, tx_frame;
   logic [15:0] twp, rwp;
   logic [2:0] rs;
   logic rx_f, line, rdone, marker, match, wake_a, miss_a, deliver;
   logic idle_arm, idle_ev;
   logic [7:0] idle_cnt, idle_len;
   logic [4:0] ckd_r;
   logic ckf_r, ck_act;

   // Byte-lane merge of a write
   function automatic logic [31:0] ufb_merge(input logic [31:0] o,
      input logic [31:0] w, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (w & m);
   endfunction : ufb_merge

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_s_n = rst_q[1];

   // Bus decode
   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = acc & wb_we_i;
   assign rd = acc & ~wb_we_i;
   assign hit_c = wb_adr_i == `UFB_OFS_CTRL;
   assign hit_s = wb_adr_i == `UFB_OFS_STAT;
   assign hit_d = wb_adr_i == `UFB_OFS_DATA;
   assign hit_b = wb_adr_i == `UFB_OFS_BAUD;
   assign hit_a = wb_adr_i == `UFB_OFS_ADDR;
   assign c_nxt = ufb_pkg::ufb_ctrl_t'(ufb_merge(c_r, wb_dat_i,
      wb_sel_i) & `UFB_CTRL_WMASK);
   assign stat_w = {23'h0, tx_buffer_empty_flag_r & c_r.tx_buffer_empty_irq_en,
      bev_r, mute_r, idle_r, brk_r, ferr_r, rxf_r, tdc_r, tx_buffer_empty_flag_r};

   // Ack one cycle after request, read data with it
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= acc;
         if (rd) begin
            if (hit_c) wb_dat_o <= c_r;
            else if (hit_s) wb_dat_o <= stat_w;
            else if (hit_d) wb_dat_o <= {23'h0, rx_data_r};
            else if (hit_b) wb_dat_o <= {16'h0, baud_r};
            else if (hit_a) wb_dat_o <= {24'h0, node_r};
            else wb_dat_o <= 32'h0;
         end
      end
   end

   // Byte-lane merges of the narrow registers
   assign baud_m = ufb_merge({16'h0, baud_r}, wb_dat_i, wb_sel_i);
   assign node_m = ufb_merge({24'h0, node_r}, wb_dat_i, wb_sel_i);

   // Software registers
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         c_r <= '0;
         baud_r <= `UFB_BAUD_RST;
         node_r <= 8'h00;
         tx_hold <= 9'h000;
      end else if (wr) begin
         if (hit_c) c_r <= c_nxt;
         if (hit_b) baud_r <= baud_m[15:0];
         if (hit_a) node_r <= node_m[7:0];
         if (hit_d) tx_hold <= wb_dat_i[8:0];
      end
   end

   // Frame geometry
   always_comb begin
      case (c_r.word_length_code)
         `UFB_WL_7: n = 4'h7;
         `UFB_WL_9: n = 4'h9;
         default: n = 4'h8;
      endcase
      case (c_r.stop_length_code)
         `UFB_STOP_1: stop_tk = `UFB_TK_BIT;
         `UFB_STOP_H: stop_tk = `UFB_TK_MID;
         `UFB_STOP_2: stop_tk = `UFB_TK_STOP2;
         default: stop_tk = `UFB_TK_STOP1H;
      endcase
   end
   assign d = n - {3'h0, c_r.parity_enable};
   assign dmask = 9'((10'h001 << d) - 10'h001);
   assign amask = dmask >> 1;

   // Per-bit ordering for both directions
   assign twp = {7'h00, tx_hold ^ {9{c_r.data_invert}}};
   assign raw = 9'(rx_sh >> (`UFB_SH_W - n));
   assign rwp = {7'h00, raw};
   for (genvar i = 0; i < 9; i++) begin : g_ord
      logic [3:0] ri;
      assign ri = 4'(d - 4'(i) - 4'h1);
      assign tord[i] = (4'(i) < d) & (c_r.msb_first_sel ?
         twp[ri] : twp[i]);
      assign rord[i] = (4'(i) < d) & (c_r.msb_first_sel ?
         rwp[ri] : rwp[i]);
   end
   assign pb = (^tord) ^ c_r.parity_odd;
   assign tx_par = 9'({8'h00, pb} << d);
   assign tx_frame = tord | (c_r.parity_enable ? tx_par : 9'h0);
   assign rxw = rord ^ ({9{c_r.data_invert}} & dmask);

   // Enables and baud counter clearing
   assign go = c_r.unit_enable & c_r.transmitter_enable;
   assign rgo = c_r.unit_enable & c_r.receiver_enable;
   assign fell = (te_q & ~c_r.transmitter_enable) |
      (re_q & ~c_r.receiver_enable);
   assign bclr = ~c_r.unit_enable | fell |
      (~c_r.transmitter_enable & ~c_r.receiver_enable);
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         te_q <= 1'b0;
         re_q <= 1'b0;
         go_q <= 1'b0;
      end else begin
         te_q <= c_r.transmitter_enable;
         re_q <= c_r.receiver_enable;
         go_q <= go;
      end
   end

   ufb_baud #(.DIV_W(16)) u_baud (
      .mclk(mclk),
      .rst_s_n(rst_s_n),
      .clr(bclr),
      .div(baud_r),
      .os_tick(os_tick)
   );

   // Transmit work selection
   assign ld_any = go & (tx_st == ufb_pkg::UFB_S_IDLE) &
      (idle_pend_r | brk_pend_r | ~tx_buffer_empty_flag_r);
   assign ld_data = ld_any & ~idle_pend_r & ~brk_pend_r;
   assign tx_end = (tx_st == ufb_pkg::UFB_S_STOP) & os_tick &
      (tx_tk == 5'h00);

   // Pending idle and break frames
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         idle_pend_r <= 1'b0;
         brk_pend_r <= 1'b0;
      end else begin
         if (go & ~go_q) idle_pend_r <= 1'b1;
         else if (ld_any | ~go) idle_pend_r <= 1'b0;
         if (wr & hit_c & wb_dat_i[`UFB_BRK_BIT] & wb_sel_i[2])
            brk_pend_r <= 1'b1;
         else if (ld_any & ~idle_pend_r) brk_pend_r <= 1'b0;
      end
   end

   // Transmit shifter, 16 ticks per bit
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         tx_st <= ufb_pkg::UFB_S_IDLE;
         tx_tk <= 5'h00;
         tx_bit <= 4'h0;
         tx_sh <= 9'h000;
         k_idle <= 1'b0;
         k_brk <= 1'b0;
      end else if (!go) begin
         tx_st <= ufb_pkg::UFB_S_IDLE;
      end else begin
         case (tx_st)
            ufb_pkg::UFB_S_IDLE: begin
               if (ld_any) begin
                  tx_st <= ufb_pkg::UFB_S_START;
                  tx_tk <= `UFB_TK_BIT;
                  k_idle <= idle_pend_r;
                  k_brk <= ~idle_pend_r & brk_pend_r;
                  if (idle_pend_r) tx_sh <= 9'h1FF;
                  else if (brk_pend_r) tx_sh <= 9'h000;
                  else tx_sh <= tx_frame;
               end
            end
            ufb_pkg::UFB_S_START: begin
               if (os_tick && tx_tk == 5'h00) begin
                  tx_st <= ufb_pkg::UFB_S_DATA;
                  tx_tk <= `UFB_TK_BIT;
                  tx_bit <= n - 4'h1;
               end else if (os_tick) tx_tk <= tx_tk - 5'h01;
            end
            ufb_pkg::UFB_S_DATA: begin
               if (os_tick && tx_tk == 5'h00) begin
                  tx_sh <= tx_sh >> 1;
                  tx_bit <= tx_bit - 4'h1;
                  tx_tk <= (tx_bit == 4'h0) ? stop_tk : `UFB_TK_BIT;
                  if (tx_bit == 4'h0) tx_st <= ufb_pkg::UFB_S_STOP;
               end else if (os_tick) tx_tk <= tx_tk - 5'h01;
            end
            ufb_pkg::UFB_S_STOP: begin
               // Break: low stop slot, then one extra high stop bit
               if (tx_end && k_brk) begin
                  k_brk <= 1'b0;
                  tx_tk <= `UFB_TK_BIT;
               end else if (tx_end) tx_st <= ufb_pkg::UFB_S_IDLE;
               else if (os_tick) tx_tk <= tx_tk - 5'h01;
            end
            default: tx_st <= ufb_pkg::UFB_S_IDLE;
         endcase
      end
   end

   // Line level, pin inversion last
   always_comb begin
      case (tx_st)
         ufb_pkg::UFB_S_START: lvl = k_idle;
         ufb_pkg::UFB_S_DATA: lvl = tx_sh[0];
         ufb_pkg::UFB_S_STOP: lvl = ~k_brk;
         default: lvl = 1'b1;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) tx_o <= 1'b1;
      else tx_o <= lvl ^ c_r.tx_pin_invert;
   end

   // Synchronous clock: per-bit pulse or free prescaled clock
   assign ck_act = (tx_st == ufb_pkg::UFB_S_DATA) & ~k_idle & ~k_brk &
      ((tx_bit != 4'h0) | c_r.last_bit_clock_pulse);
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         ckd_r <= 5'h00;
         ckf_r <= 1'b0;
         ck_o <= 1'b0;
         ck_oe <= 1'b0;
      end else begin
         if (ckd_r + 5'h01 >= c_r.output_clock_prescale) begin
            ckd_r <= 5'h00;
            ckf_r <= ~ckf_r;
         end else ckd_r <= ckd_r + 5'h01;
         ck_oe <= c_r.clock_output_enable;
         if (c_r.output_clock_prescale != 5'h00) ck_o <= ckf_r;
         else if (ck_act) ck_o <= c_r.clock_idle_level ^
            (c_r.clock_sample_edge ? tx_tk[3] : ~tx_tk[3]);
         else ck_o <= c_r.clock_idle_level;
      end
   end

   // Receive input, three flops, change when last two agree
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         rs <= 3'h7;
         rx_f <= 1'b1;
      end else begin
         rs <= {rs[1:0], rx_i};
         if (rs[1] == rs[2]) rx_f <= rs[2];
      end
   end
   assign line = rx_f ^ c_r.rx_pin_invert;
   assign rdone = (rx_st == ufb_pkg::UFB_S_STOP) & os_tick &
      (rx_tk == 5'h00);

   // Receive shifter, mid-bit sampling
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         rx_st <= ufb_pkg::UFB_S_IDLE;
         rx_tk <= 5'h00;
         rx_bit <= 4'h0;
         rx_sh <= 9'h000;
      end else if (!rgo) begin
         rx_st <= ufb_pkg::UFB_S_IDLE;
      end else begin
         case (rx_st)
            ufb_pkg::UFB_S_IDLE: begin
               if (!line) begin
                  rx_st <= ufb_pkg::UFB_S_START;
                  rx_tk <= `UFB_TK_MID;
               end
            end
            ufb_pkg::UFB_S_START: begin
               if (os_tick && rx_tk == 5'h00) begin
                  rx_st <= line ? ufb_pkg::UFB_S_IDLE :
                     ufb_pkg::UFB_S_DATA;
                  rx_tk <= `UFB_TK_BIT;
                  rx_bit <= n - 4'h1;
               end else if (os_tick) rx_tk <= rx_tk - 5'h01;
            end
            ufb_pkg::UFB_S_DATA: begin
               if (os_tick && rx_tk == 5'h00) begin
                  rx_sh <= {line, rx_sh[8:1]};
                  rx_bit <= rx_bit - 4'h1;
                  rx_tk <= `UFB_TK_BIT;
                  if (rx_bit == 4'h0) rx_st <= ufb_pkg::UFB_S_STOP;
               end else if (os_tick) rx_tk <= rx_tk - 5'h01;
            end
            ufb_pkg::UFB_S_STOP: begin
               if (rdone) rx_st <= ufb_pkg::UFB_S_IDLE;
               else if (os_tick) rx_tk <= rx_tk - 5'h01;
            end
            default: rx_st <= ufb_pkg::UFB_S_IDLE;
         endcase
      end
   end

   // Address word decode
   assign marker = |(rxw & ~amask & dmask);
   assign match = c_r.address_width_sel ?
      ((rxw & amask) == ({1'b0, node_r} & amask)) :
      (rxw[3:0] == node_r[3:0]);
   assign wake_a = rdone & c_r.wake_method & marker & match;
   assign miss_a = rdone & c_r.wake_method & marker & ~match;
   assign deliver = rdone & (~mute_r | wake_a);

   // Idle line after traffic, one frame of ones
   assign idle_len = 8'({n + 4'h2, 4'h0} - 8'h01);
   assign idle_ev = idle_arm & os_tick & (idle_cnt == idle_len);
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         idle_arm <= 1'b0;
         idle_cnt <= 8'h00;
      end else begin
         if (rdone | (wr & hit_c & c_nxt.receiver_mute)) idle_arm <= 1'b1;
         else if (idle_ev) idle_arm <= 1'b0;
         if (!rgo || rx_st != ufb_pkg::UFB_S_IDLE || !line || idle_ev)
            idle_cnt <= 8'h00;
         else if (os_tick) idle_cnt <= idle_cnt + 8'h01;
      end
   end

   // Silent state
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) mute_r <= 1'b0;
      else if (wr & hit_c & c_nxt.receiver_mute) mute_r <= 1'b1;
      else if (wake_a | (~c_r.wake_method & idle_ev)) mute_r <= 1'b0;
      else if (c_r.receiver_mute & miss_a) mute_r <= 1'b1;
   end

   // Flags, hardware set wins over software clear; a data write wins over the empty flag set
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         tx_buffer_empty_flag_r <= 1'b1;
         tdc_r <= 1'b1;
         rxf_r <= 1'b0;
         ferr_r <= 1'b0;
         brk_r <= 1'b0;
         idle_r <= 1'b0;
         bev_r <= 1'b0;
         rx_data_r <= 9'h000;
      end else begin
         if (wr & hit_d) tx_buffer_empty_flag_r <= 1'b0;
         else if (ld_data) tx_buffer_empty_flag_r <= 1'b1;
         if (tx_end & tx_buffer_empty_flag_r & ~idle_pend_r & ~brk_pend_r & ~k_brk)
            tdc_r <= 1'b1;
         else if (wr & hit_d) tdc_r <= 1'b0;
         if (deliver) rxf_r <= 1'b1;
         else if (rd & hit_d) rxf_r <= 1'b0;
         if (deliver) rx_data_r <= rxw;
         if (rdone & ~line) ferr_r <= 1'b1;
         else if (wr & hit_s & wb_dat_i[`UFB_ST_FERR]) ferr_r <= 1'b0;
         if (rdone & ~line & (raw == 9'h000)) brk_r <= 1'b1;
         else if (wr & hit_s & wb_dat_i[`UFB_ST_BRK]) brk_r <= 1'b0;
         if (idle_ev) idle_r <= 1'b1;
         else if (wr & hit_s & wb_dat_i[`UFB_ST_IDLE]) idle_r <= 1'b0;
         if (fell) bev_r <= 1'b1;
         else if (wr & hit_s & wb_dat_i[`UFB_ST_BEV]) bev_r <= 1'b0;
      end
   end

   // DMA requests
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         tx_dma_req <= 1'b0;
         rx_dma_req <= 1'b0;
      end else begin
         tx_dma_req <= c_r.tx_dma_en & tx_buffer_empty_flag_r & go;
         rx_dma_req <= c_r.rx_dma_en & rxf_r;
      end
   end

   // Checks
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_s_n);
   property p_wr_full;
      wr && hit_d |=> !tx_buffer_empty_flag_r;
   endproperty
   a_wr_full: assert property (p_wr_full)
      else $error("empty flag stayed set after data write");
   property p_dma_tx;
      tx_dma_req |-> $past(tx_buffer_empty_flag_r) && $past(c_r.tx_dma_en);
   endproperty
   a_dma_tx: assert property (p_dma_tx)
      else $error("transmit request without empty holding word");
   property p_bev;
      c_r.unit_enable && fell |=> bev_r;
   endproperty
   a_bev: assert property (p_bev)
      else $error("disable did not flag baud event");
   property p_idle_ones;
      go && k_idle && tx_st != ufb_pkg::UFB_S_IDLE ##1 go |->
         tx_o == c_r.tx_pin_invert ^ 1'b1;
   endproperty
   a_idle_ones: assert property (p_idle_ones)
      else $error("idle frame line not at one");
   property p_start_low;
      go && !k_idle && tx_st == ufb_pkg::UFB_S_START ##1 go |->
         tx_o == c_r.tx_pin_invert;
   endproperty
   a_start_low: assert property (p_start_low)
      else $error("start bit not low");
   property p_brk_low;
      go && k_brk && tx_st == ufb_pkg::UFB_S_DATA ##1 go |->
         tx_o == c_r.tx_pin_invert;
   endproperty
   a_brk_low: assert property (p_brk_low)
      else $error("break data bit not low");
   property p_stop_len;
      go && tx_st == ufb_pkg::UFB_S_STOP &&
         $past(tx_st) == ufb_pkg::UFB_S_DATA |-> tx_tk == stop_tk;
   endproperty
   a_stop_len: assert property (p_stop_len)
      else $error("stop length load wrong");
   property p_ck_idle;
      c_r.output_clock_prescale == 5'h00 && !ck_act |=>
         ck_o == $past(c_r.clock_idle_level);
   endproperty
   a_ck_idle: assert property (p_ck_idle)
      else $error("clock not at idle level outside data");
   property p_wake;
      wake_a && !(wr && hit_c) |=> !mute_r && rxf_r;
   endproperty
   a_wake: assert property (p_wake)
      else $error("address match did not wake");
   property p_first_idle;
      go && !go_q && tx_st == ufb_pkg::UFB_S_IDLE |=> ##[0:2]
         (k_idle && tx_st == ufb_pkg::UFB_S_START) || !go;
   endproperty
   a_first_idle: assert property (p_first_idle)
      else $error("no idle frame after transmitter enable");
   c_data: cover property (ld_data ##[1:1000] tx_end);
   c_idle: cover property (go && k_idle && tx_end);
   c_wake: cover property (mute_r ##1 !mute_r);
   c_brk: cover property (rdone && !line && raw == 9'h000);
endmodule : ufb_usart_core
`default_nettype wire

//--- verification/ufb_node.sv
// Purpose: Remote serial node driving the receive line
// Assumes: Divisor 16, eight data bits, no parity
// Notes: Line rests high between frames
`timescale 1ns/100ps
`default_nettype none
module ufb_node (
   // Clock
   input wire logic mclk,
   // Line into the core
   output logic rx_line
);
   initial rx_line = 1'b1;
   // Start, data lsb first, one stop
   task automatic send(input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int b = 0; b < 10; b++) begin
         rx_line <= f[b];
         repeat (16) @(posedge mclk);
      end
   endtask : send
endmodule : ufb_node
`default_nettype wire

//--- verification/ufb_usart_core_bench.sv
// Purpose: Self-checking bench of the serial core
// Assumes: Divisor 16, eight data bits, one stop
// Notes: Register rows first, then frame tests
`timescale 1ns/100ps
`default_nettype none
module ufb_usart_core_bench;
   logic mclk, rst_n, cyc, we, ack, rx, tx;
   logic ck, ckoe, txd, rxd;
   logic [7:0] adr;
   logic [31:0] wd, rd, got;
   logic [39:0] rows [5];
   int mismatches, n_checks, cyc_n, t;
   ufb_usart_core dut(.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .rx_i(rx), .tx_o(tx),
      .ck_o(ck), .ck_oe(ckoe), .tx_dma_req(txd), .rx_dma_req(rxd));
   ufb_node node(.mclk(mclk), .rx_line(rx));
   // Clock, 4 ns period
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   // Classic single cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge mclk); while (ack !== 1'b1);
      got = rd;
      cyc <= 1'b0;
   endtask : bus
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Waits for a start bit, then checks line and clock at mid-bit
   task automatic frame(input logic [7:0] e);
      while (tx !== 1'b0) @(posedge mclk);
      repeat (8) @(posedge mclk);
      chk(tx, 1'b0);
      for (int b = 0; b < 8; b++) begin
         repeat (16) @(posedge mclk);
         chk({tx, ck}, {e[b], b != 7});
      end
      repeat (16) @(posedge mclk);
      chk({tx, ck}, 2'h2);
   endtask : frame
   task automatic end_sim();
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      rows = '{{8'h00, 32'h0}, {8'h04, 32'h3}, {8'h0C, 32'h10},
         {8'h10, 32'h0}, {8'h14, 32'h0}};
      rst_n = 1'b0;
      cyc = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wd = 32'h0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({tx, ck, ckoe, txd, rxd}, 5'h10);
      // Reset values, unmapped place reads zero
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, rows[i][39:32], 32'h0);
         chk(got, rows[i][31:0]);
      end
      // Divisor first, then enable; idle frame precedes data
      bus(1'b1, 8'h0C, 32'h10);
      bus(1'b1, 8'h00, 32'h0608_0038);
      while (txd !== 1'b1) @(posedge mclk);
      bus(1'b1, 8'h08, 32'hA5);
      bus(1'b0, 8'h04, 32'h0);
      chk({got[0], txd, ckoe}, 3'h1);
      t = 0;
      while (tx !== 1'b0) begin
         @(posedge mclk);
         t++;
      end
      chk(t >= 150, 1'b1);
      frame(8'hA5);
      bus(1'b0, 8'h04, 32'h0);
      chk({got[0], txd}, 2'h3);
      // Remote node sends a word back
      node.send(8'h3C);
      bus(1'b0, 8'h04, 32'h0);
      chk({got[2], rxd}, 2'h3);
      bus(1'b0, 8'h08, 32'h0);
      chk(got[7:0], 8'h3C);
      @(posedge mclk);
      chk(rxd, 1'b0);
      // Silent until a marked word carries the node address
      bus(1'b1, 8'h10, 32'h05);
      bus(1'b1, 8'h00, 32'h0608_00F8);
      node.send(8'h12);
      bus(1'b0, 8'h04, 32'h0);
      chk({got[6], got[2]}, 2'h2);
      node.send(8'h85);
      bus(1'b0, 8'h04, 32'h0);
      chk({got[6], got[2]}, 2'h1);
      bus(1'b0, 8'h08, 32'h0);
      chk(got[7:0], 8'h85);
      // Msb first, even parity in the last slot
      bus(1'b1, 8'h00, 32'h0608_A038);
      bus(1'b1, 8'h08, 32'h25);
      frame(8'hD2);
      // Break: ten low bits, then a high stop
      bus(1'b1, 8'h00, 32'h0688_A038);
      while (tx !== 1'b0) @(posedge mclk);
      repeat (152) @(posedge mclk);
      chk({tx, ck}, 2'h0);
      repeat (16) @(posedge mclk);
      chk(tx, 1'b1);
      end_sim();
   end
endmodule : ufb_usart_core_bench
`default_nettype wire
